/* src/p9g_port.sv */
// port nine general-purpose pins with shared peripheral functions
//
// Behaviour
// - eight pins, each direction bit: 1 output, 0 input
// - direction register is write-only and resets to all zero
// - direction 0 releases the pin driver, pin is an input
// - direction 1 drives pins 7 and 5..0; pin 6 outputs system clock while subclock input enable is 0
// - data latch holds the output value of pins 7 and 5..0, driven in output mode
// - read of output-mode bit except bit 6 returns latched value
// - read of input-mode bit returns sampled pin level
// - bit 6 is read-only and always returns the sampled pin level
// - latch bits reset to zero; bit 6 follows pin six
// - with derived i2c enable, pin 7 is i2c data, direction ignored
// - i2c data pin only pulls low or releases; plain output drives both
// - pin 6: input, subclock input, or system clock output by bits
// - pins 5, 4, 3 are plain inputs or outputs only
// - interrupt zero enable passes pin 2 level to interrupt zero
// - interrupt one enable passes pin 1 level to interrupt one
// - interrupt two enable passes pin 0 level to interrupt two
// - both trigger selects pass pin 0 level to converter trigger
`timescale 1ns/1ps
`default_nettype none
module p9g_port
  import p9g_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // pads
  input wire logic [7:0] pin_i,
  output p9g_pad_t pad_o,
  // i2c unit: 1 asks the data line low
  input wire logic i2c_data_drive_low_i,
  // levels handed to peripherals
  output p9g_peri_t peri_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] direction;
    logic [7:0] latch;
    p9g_fsel_t fsel;
    logic [31:0] rdata;
    p9g_pad_t pad;
    logic clk_out;
    p9g_peri_t peri;
  } p9g_st_t;

  p9g_st_t st_r;
  p9g_st_t st_nxt;

  // ----------------------------------------------------------------
  // bus front end and synchroniser
  // ----------------------------------------------------------------
  p9g_reg_t reg_sel;
  logic capture;
  logic write;
  logic [7:0] level;

  p9g_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .reg_o(reg_sel),
    .capture_o(capture),
    .write_o(write)
  );

  p9g_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(pin_i),
    .level_o(level)
  );

  // ----------------------------------------------------------------
  // pin function decode
  // ----------------------------------------------------------------
  logic i2c_route;
  logic clk_sel;
  logic subclk_sel;
  logic trig_sel;
  logic [7:0] read_port;
  logic [7:0] oe_vec;
  logic [7:0] o_vec;

  // derived i2c routing enable
  assign i2c_route = st_r.fsel.i2c_unit_enable &
                     ~(st_r.fsel.i2c_route_select_a & st_r.fsel.i2c_route_select_b);
  assign clk_sel = st_r.direction[P9G_PIN_CLK] & ~st_r.fsel.subclock_input_enable;
  assign subclk_sel = ~st_r.direction[P9G_PIN_CLK] & st_r.fsel.subclock_input_enable;
  assign trig_sel = st_r.fsel.trigger_select_high & st_r.fsel.trigger_select_low;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      if (g == P9G_PIN_I2C) begin : g_i2c
        // open drain while the i2c unit owns the pin
        assign oe_vec[g] = i2c_route ? i2c_data_drive_low_i : st_r.direction[g];
        assign o_vec[g] = i2c_route ? 1'b0 : st_r.latch[g];
        assign read_port[g] = st_r.direction[g] ? st_r.latch[g] : level[g];
      end else if (g == P9G_PIN_CLK) begin : g_clk
        // the latch never reaches this pin; direction 1 with subclock on is released
        assign oe_vec[g] = clk_sel;
        assign o_vec[g] = 1'b0;
        assign read_port[g] = level[g];
      end else begin : g_plain
        assign oe_vec[g] = st_r.direction[g];
        assign o_vec[g] = st_r.latch[g];
        assign read_port[g] = st_r.direction[g] ? st_r.latch[g] : level[g];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // register writes
    if (write) begin
      unique case (reg_sel)
        P9G_REG_DIRECTION: st_nxt.direction = wb_dat_i[7:0];
        P9G_REG_LATCH: begin
          st_nxt.latch = wb_dat_i[7:0];
          st_nxt.latch[P9G_PIN_CLK] = 1'b0;
        end
        P9G_REG_FSEL: st_nxt.fsel = p9g_fsel_t'(wb_dat_i[8:0]);
        P9G_REG_STATUS: st_nxt.fsel = st_r.fsel;
      endcase
    end
    // read data is captured as the request is taken
    if (capture) begin
      st_nxt.rdata = 32'h00000000;
      unique case (reg_sel)
        P9G_REG_DIRECTION: st_nxt.rdata = 32'h00000000;
        P9G_REG_LATCH: st_nxt.rdata[7:0] = read_port;
        P9G_REG_FSEL: st_nxt.rdata[8:0] = st_r.fsel;
        P9G_REG_STATUS: begin
          st_nxt.rdata[P9G_ST_I2C] = i2c_route;
          st_nxt.rdata[P9G_ST_CLKOUT] = clk_sel;
          st_nxt.rdata[P9G_ST_SUBCLK] = subclk_sel;
          st_nxt.rdata[P9G_ST_TRIG] = trig_sel;
          st_nxt.rdata[P9G_ST_OE_LSB +: 8] = st_r.pad.oe;
        end
      endcase
    end
    // pad and peripheral outputs, one register stage after the control state
    st_nxt.pad.oe = oe_vec;
    st_nxt.pad.o = o_vec;
    st_nxt.clk_out = clk_sel;
    st_nxt.peri.i2c_data_line = level[P9G_PIN_I2C] | ~i2c_route;
    // the rule on direction 0 is software's; hardware just refuses the mix
    st_nxt.peri.subclock_input = level[P9G_PIN_CLK] & subclk_sel;
    st_nxt.peri.ext_interrupt[0] = level[P9G_PIN_EXT_INTERRUPT_ZERO] &
                                   st_r.fsel.ext_interrupt_zero_enable;
    st_nxt.peri.ext_interrupt[1] = level[P9G_PIN_EXT_INTERRUPT_ONE] &
                                   st_r.fsel.ext_interrupt_one_enable;
    st_nxt.peri.ext_interrupt[2] = level[P9G_PIN_EXT_INTERRUPT_TWO] &
                                   st_r.fsel.ext_interrupt_two_enable;
    st_nxt.peri.conversion_trigger_input = level[P9G_PIN_TRIG] & trig_sel;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.direction <= P9G_RST_DIRECTION;
      st_r.latch <= P9G_RST_LATCH;
      st_r.fsel <= p9g_fsel_t'(P9G_RST_FSEL);
      st_r.rdata <= 32'h00000000;
      st_r.pad <= '0;
      st_r.clk_out <= 1'b0;
      st_r.peri <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the system clock is gated straight onto pin 6; a flop could only halve it
  always_comb begin
    pad_o = st_r.pad;
    pad_o.o[P9G_PIN_CLK] = clk_i & st_r.clk_out;
  end

  assign wb_dat_o = st_r.rdata;
  assign peri_o = st_r.peri;

endmodule : p9g_port
`default_nettype wire

/* src/p9g_pkg.sv */
// shared constants and carrier types of the port nine pin multiplexer
package p9g_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] P9G_ADR_DIRECTION = 8'h00;
  localparam logic [7:0] P9G_ADR_LATCH = 8'h04;
  localparam logic [7:0] P9G_ADR_FSEL = 8'h08;
  localparam logic [7:0] P9G_ADR_STATUS = 8'h0c;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] P9G_RST_DIRECTION = 8'h00;
  localparam logic [7:0] P9G_RST_LATCH = 8'h00;
  localparam logic [8:0] P9G_RST_FSEL = 9'h000;

  // ----------------------------------------------------------------
  // pin positions with an alternate function
  // ----------------------------------------------------------------
  localparam int P9G_PIN_I2C = 7;
  localparam int P9G_PIN_CLK = 6;
  localparam int P9G_PIN_EXT_INTERRUPT_ZERO = 2;
  localparam int P9G_PIN_EXT_INTERRUPT_ONE = 1;
  localparam int P9G_PIN_EXT_INTERRUPT_TWO = 0;
  localparam int P9G_PIN_TRIG = 0;

  // ----------------------------------------------------------------
  // status register field positions
  // ----------------------------------------------------------------
  localparam int P9G_ST_I2C = 0;
  localparam int P9G_ST_CLKOUT = 1;
  localparam int P9G_ST_SUBCLK = 2;
  localparam int P9G_ST_TRIG = 3;
  localparam int P9G_ST_OE_LSB = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // function select bits, msb first: see field order below
  typedef struct packed {
    logic trigger_select_high;
    logic trigger_select_low;
    logic ext_interrupt_two_enable;
    logic ext_interrupt_one_enable;
    logic ext_interrupt_zero_enable;
    logic subclock_input_enable;
    logic i2c_route_select_b;
    logic i2c_route_select_a;
    logic i2c_unit_enable;
  } p9g_fsel_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } p9g_pad_t;

  typedef struct packed {
    logic [2:0] ext_interrupt;
    logic conversion_trigger_input;
    logic subclock_input;
    logic i2c_data_line;
  } p9g_peri_t;

  typedef enum logic [1:0] {
    P9G_REG_DIRECTION,
    P9G_REG_LATCH,
    P9G_REG_FSEL,
    P9G_REG_STATUS
  } p9g_reg_t;

endpackage : p9g_pkg

/* src/p9g_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module p9g_sync
  import p9g_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins
  input wire logic [7:0] raw_i,
  output logic [7:0] level_o
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
  } p9g_sync_st_t;

  p9g_sync_st_t st_r;
  p9g_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = raw_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // s1 feeds only s2; a level counts once s2 and s3 agree
    for (int i = 0; i < 8; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.lvl;

endmodule : p9g_sync
`default_nettype wire

/* src/p9g_wb_slave.sv */
// classic wishbone slave front end: decode, ack and error timing
`timescale 1ns/1ps
`default_nettype none
module p9g_wb_slave
  import p9g_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone request
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  // wishbone answer
  output logic wb_ack_o,
  output logic wb_err_o,
  // towards the register file
  output p9g_reg_t reg_o,
  output logic capture_o,
  output logic write_o
);

  typedef struct packed {
    logic ack;
    logic err;
  } p9g_wb_st_t;

  p9g_wb_st_t st_r;
  p9g_wb_st_t st_nxt;
  logic mapped;
  logic start;

  always_comb begin
    mapped = 1'b1;
    reg_o = P9G_REG_DIRECTION;
    unique case (wb_adr_i[7:0])
      P9G_ADR_DIRECTION: reg_o = P9G_REG_DIRECTION;
      P9G_ADR_LATCH: reg_o = P9G_REG_LATCH;
      P9G_ADR_FSEL: reg_o = P9G_REG_FSEL;
      P9G_ADR_STATUS: reg_o = P9G_REG_STATUS;
      default: mapped = 1'b0;
    endcase
    if (wb_adr_i[31:8] != 24'h000000) begin
      mapped = 1'b0;
    end
  end

  // one answer per request; the answer drops the cycle after it is given
  assign start = wb_cyc_i & wb_stb_i & ~st_r.ack & ~st_r.err;

  always_comb begin
    st_nxt.ack = start & mapped;
    st_nxt.err = start & ~mapped;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign capture_o = start & mapped;
  // writes land on the edge where the master samples ack
  assign write_o = wb_cyc_i & wb_stb_i & wb_we_i & st_r.ack & wb_sel_i[0];
  assign wb_ack_o = st_r.ack;
  assign wb_err_o = st_r.err;

endmodule : p9g_wb_slave
`default_nettype wire

/* sim/p9g_board.sv */
// board model for port nine: outside drivers, data-line pull-up, contention
`timescale 1ns/1ps
`default_nettype none
module p9g_board
  import p9g_pkg::*;
(
  // clock
  input wire logic clk_i,
  // pads and outside drive
  input wire p9g_pad_t pad_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_o
);
  logic [7:0] last_r;
  always_ff @(posedge clk_i) begin
    last_r <= pin_o;
  end
  // a fight between two drivers reads as unknown; a floating pin 0..6 toggles each edge, pin 7 pulls high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_i.oe[i] && ext_en_i[i]) begin
        pin_o[i] = 1'bx;
      end else if (pad_i.oe[i]) begin
        pin_o[i] = pad_i.o[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else begin
        pin_o[i] = (i == 7) ? 1'b1 : ~last_r[i];
      end
    end
  end
endmodule : p9g_board
`default_nettype wire

/* sim/p9g_port_sva.sv */
// assertions on the port nine pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module p9g_port_sva
  import p9g_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and pins
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] pin_i,
  input wire p9g_pad_t pad_o,
  input wire p9g_peri_t peri_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // edges since a pin was high (data line: low)
  // ----------------------------------------
  // the synchroniser lags, so a handed-on level trails its pin by a few edges
  logic [3:0] age_r [8];
  logic [3:0] low7_r;
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      age_r[i] <= rst_i ? 4'hf : pin_i[i] ? 4'h0 : age_r[i] + {3'h0, age_r[i] != 4'hf};
    end
    low7_r <= (rst_i || !pin_i[7]) ? 4'h0 : low7_r + {3'h0, low7_r != 4'hf};
  end
  AST_RST_QUIET: assert property ($fell(rst_i) |-> pad_o.oe == 8'h00 && peri_o == '0)
    else $error("pads or peripherals active after reset");
  AST_OE_WRITE: assert property ($rose(|pad_o.oe[6:0]) |-> $past(wb_ack_o && wb_we_i, 2))
    else $error("pin driver enabled without a register write");
  AST_EXT_INTERRUPT_ZERO: assert property (peri_o.ext_interrupt[0] |-> age_r[2] < 4'h8)
    else $error("interrupt zero high without pin two high");
  AST_EXT_INTERRUPT_ONE: assert property (peri_o.ext_interrupt[1] |-> age_r[1] < 4'h8)
    else $error("interrupt one high without pin one high");
  AST_EXT_INTERRUPT_TWO: assert property (peri_o.ext_interrupt[2] |-> age_r[0] < 4'h8)
    else $error("interrupt two high without pin zero high");
  AST_TRIG: assert property (peri_o.conversion_trigger_input |-> age_r[0] < 4'h8)
    else $error("trigger high without pin zero high");
  AST_SUBCLK: assert property (peri_o.subclock_input |-> age_r[6] < 4'h8)
    else $error("subclock high without pin six high");
  AST_I2C_LOW: assert property (!peri_o.i2c_data_line |-> low7_r < 4'h8)
    else $error("data line low without pin seven low");
  COV_WRITE: cover property (wb_ack_o && wb_we_i);
  COV_PULL: cover property (pad_o.oe[7] && !pad_o.o[7]);
  COV_TRIG: cover property (peri_o.conversion_trigger_input);
endmodule : p9g_port_sva
bind p9g_port p9g_port_sva p9g_port_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pad_o(pad_o), .peri_o(peri_o));
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the port nine pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import p9g_pkg::*;
();
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, drv_low, got_err;
  logic [31:0] wb_adr, wb_dat, wb_q, rq;
  logic [7:0] pin, ext_en, ext_val;
  p9g_pad_t pad;
  p9g_peri_t peri;
  int failures = 0;
  int num_checks = 0;
  p9g_port p9g_port_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
    .wb_ack_o(wb_ack), .wb_err_o(wb_err), .pin_i(pin), .pad_o(pad),
    .i2c_data_drive_low_i(drv_low), .peri_o(peri));
  p9g_board p9g_board_inst (.clk_i(clk_i), .pad_i(pad), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_o(pin));
  always #5 clk_i = ~clk_i;
  // ----------------------------------------
  // bus, compare and scenario tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] a, input logic [8:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {24'h0, a};
    wb_dat <= {23'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rq = wb_q;
    got_err = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // pin levels need the synchroniser's edges plus one register
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle
  task automatic t_reset();
    settle();
    chk(pad.oe, 8'h00);
    bus(1'b0, P9G_ADR_DIRECTION, 9'h000);
    chk(rq[7:0], 8'h00);
    ext_en <= 8'h40;
    bus(1'b1, P9G_ADR_DIRECTION, 9'h0bf);
    settle();
    bus(1'b0, P9G_ADR_LATCH, 9'h000);
    chk(rq[7:0], 8'h40);
    bus(1'b0, 8'h10, 9'h000);
    chk({7'h0, got_err}, 8'h01);
  endtask : t_reset
  task automatic t_io();
    logic [7:0] dr [2] = '{8'h0f, 8'hf0};
    logic [7:0] m;
    ext_en <= 8'hff;
    bus(1'b1, P9G_ADR_LATCH, 9'h01a);
    for (int k = 0; k < 2; k++) begin
      m = dr[k][6] ? 8'hbf : 8'hff;
      bus(1'b1, P9G_ADR_DIRECTION, {1'b0, dr[k]});
      // outside drivers let go of every pin the port now drives, so nothing fights
      ext_en <= ~dr[k];
      settle();
      chk(pad.oe, dr[k]);
      chk(pad.o & dr[k] & 8'hbf, 8'h1a & dr[k] & 8'hbf);
      #1;
      chk({7'h0, pad.o[6]}, {7'h0, dr[k][6]});
      @(posedge clk_i);
      bus(1'b0, P9G_ADR_LATCH, 9'h000);
      chk(rq[7:0] & m, ((dr[k] & 8'h1a) | (~dr[k] & 8'he5)) & m);
    end
  endtask : t_io
  task automatic t_i2c();
    logic [8:0] fs [4] = '{9'h001, 9'h003, 9'h005, 9'h007};
    ext_en <= 8'h7f;
    bus(1'b1, P9G_ADR_LATCH, 9'h080);
    bus(1'b1, P9G_ADR_DIRECTION, 9'h080);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, P9G_ADR_FSEL, fs[k]);
      for (int v = 0; v < 2; v++) begin
        drv_low <= v[0];
        settle();
        chk({6'h0, pad.oe[7], pad.o[7]}, (k < 3) ? {6'h0, v[0], 1'b0} : 8'h03);
        chk({7'h0, peri.i2c_data_line}, (k < 3) ? {7'h0, !v[0]} : 8'h01);
      end
      bus(1'b0, P9G_ADR_STATUS, 9'h000);
      chk({7'h0, rq[P9G_ST_I2C]}, {7'h0, k < 3});
    end
  endtask : t_i2c
  task automatic t_alt();
    logic [8:0] fs [7] = '{9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h180, 9'h000};
    logic [5:0] pe [7] = '{6'h03, 6'h09, 6'h11, 6'h21, 6'h01, 6'h05, 6'h01};
    drv_low <= 1'b0;
    ext_en <= 8'hff;
    bus(1'b1, P9G_ADR_DIRECTION, 9'h000);
    for (int e = 0; e < 2; e++) begin
      ext_val <= e[0] ? 8'h00 : 8'h47;
      for (int k = 0; k < 7; k++) begin
        bus(1'b1, P9G_ADR_FSEL, fs[k]);
        settle();
        chk({2'h0, peri}, {2'h0, e[0] ? 6'h01 : pe[k]});
      end
    end
  endtask : t_alt
  task automatic conclude();
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 32'h0;
    wb_dat = 32'h0;
    drv_low = 1'b0;
    ext_en = 8'hff;
    ext_val = 8'he5;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_io();
    t_i2c();
    t_alt();
    conclude();
  end
  // the scenarios need well under two thousand edges
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
